// ### rtl/mgmt_serial_slave.v
// Serial management slave: frames, turnaround, read shift-out, write pulse.
// Assumes the management clock runs at most a quarter of the reference clock.
`timescale 1ns/10ps
`include "phy_basic_mode_control_defs.vh"

module mgmt_serial_slave (
  input wire ref_clk_i, // reference clock
  input wire rst_i, // synchronous reset, active high
  input wire mdc_i, // management clock pin
  input wire mdio_i, // management data pin level
  input wire [15:0] rd_data_i, // read data for reg_addr_o
  output reg mdio_o, // management data out
  output reg mdio_oe_o, // management data drive enable
  output reg [4:0] reg_addr_o, // register address of current frame
  output reg [15:0] wr_data_o, // write data
  output reg wr_stb_o // one-cycle write strobe
);

  localparam S_IDLE = 3'h0;
  localparam S_ST = 3'h1;
  localparam S_OP = 3'h2;
  localparam S_ADDR = 3'h3;
  localparam S_TA = 3'h4;
  localparam S_DATA = 3'h5;
  localparam integer GAP_INT = `MGMT_GAP_CYCLES;
  localparam [3:0] GAP_CYC = GAP_INT[3:0];

  reg mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
  reg [2:0] state_q;
  reg [4:0] cnt_q;
  reg [5:0] ones_q;
  reg pre_ok_q;
  reg seen_one_q;
  reg [3:0] gap_q;
  reg [1:0] op_q;
  reg [9:0] addr_q;
  reg mine_q;
  reg [15:0] sh_q;
  wire rise;
  wire bit_in;

  assign rise = mdc_s2_q & ~mdc_s3_q & (gap_q == 4'h0);
  assign bit_in = mdio_s2_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    mdc_s1_q <= mdc_i;
    mdc_s2_q <= mdc_s1_q;
    mdc_s3_q <= mdc_s2_q;
    mdio_s1_q <= mdio_i;
    mdio_s2_q <= mdio_s1_q;
  end

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      cnt_q <= 5'h00;
      ones_q <= 6'h00;
      pre_ok_q <= 1'b0;
      seen_one_q <= 1'b0;
      gap_q <= 4'h0;
      op_q <= 2'h0;
      addr_q <= 10'h000;
      mine_q <= 1'b0;
      sh_q <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      reg_addr_o <= 5'h00;
      wr_data_o <= 16'h0000;
      wr_stb_o <= 1'b0;
    end
    else
    begin
      wr_stb_o <= 1'b0;
      if (gap_q != 4'h0)
        gap_q <= gap_q - 4'h1;
      if (rise)
      begin
        case (state_q)
          S_IDLE:
          begin
            if (bit_in)
            begin
              seen_one_q <= 1'b1;
              if (ones_q != `MGMT_PREAMBLE_BITS)
                ones_q <= ones_q + 6'h01;
            end
            else if (ones_q == `MGMT_PREAMBLE_BITS || (pre_ok_q && seen_one_q))
              state_q <= S_ST;
            else
              ones_q <= 6'h00;
          end
          S_ST:
          begin
            cnt_q <= 5'h00;
            if (bit_in)
              state_q <= S_OP;
            else
            begin
              // Bad start: demand full preamble again
              pre_ok_q <= 1'b0;
              ones_q <= 6'h00;
              seen_one_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
          S_OP:
          begin
            op_q <= {op_q[0], bit_in};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h01)
            begin
              cnt_q <= 5'h00;
              if ({op_q[0], bit_in} == `MGMT_OP_WRITE || {op_q[0], bit_in} == `MGMT_OP_READ)
                state_q <= S_ADDR;
              else
              begin
                pre_ok_q <= 1'b0;
                ones_q <= 6'h00;
                seen_one_q <= 1'b0;
                state_q <= S_IDLE;
              end
            end
          end
          S_ADDR:
          begin
            addr_q <= {addr_q[8:0], bit_in};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h09)
            begin
              cnt_q <= 5'h00;
              mine_q <= (addr_q[8:4] == `MGMT_PHY_ADDR);
              reg_addr_o <= {addr_q[3:0], bit_in};
              state_q <= S_TA;
            end
          end
          S_TA:
          begin
            cnt_q <= cnt_q + 5'h01;
            if (op_q == `MGMT_OP_READ)
            begin
              if (cnt_q == 5'h00)
              begin
                mdio_oe_o <= mine_q;
                mdio_o <= 1'b0;
                sh_q <= rd_data_i;
              end
              else
              begin
                mdio_o <= sh_q[15];
                sh_q <= {sh_q[14:0], 1'b0};
                cnt_q <= 5'h00;
                state_q <= S_DATA;
              end
            end
            // Write turnaround must read 1 then 0
            else if (bit_in == (cnt_q == 5'h01))
            begin
              pre_ok_q <= 1'b0;
              ones_q <= 6'h00;
              seen_one_q <= 1'b0;
              state_q <= S_IDLE;
            end
            else if (cnt_q == 5'h01)
            begin
              cnt_q <= 5'h00;
              state_q <= S_DATA;
            end
          end
          S_DATA:
          begin
            cnt_q <= cnt_q + 5'h01;
            sh_q <= {sh_q[14:0], bit_in};
            if (op_q == `MGMT_OP_READ)
              mdio_o <= sh_q[15];
            if (cnt_q == 5'h0F)
            begin
              mdio_oe_o <= 1'b0;
              wr_data_o <= {sh_q[14:0], bit_in};
              wr_stb_o <= mine_q & (op_q == `MGMT_OP_WRITE);
              pre_ok_q <= 1'b1;
              ones_q <= 6'h00;
              seen_one_q <= 1'b0;
              gap_q <= GAP_CYC;
              cnt_q <= 5'h00;
              state_q <= S_IDLE;
            end
          end
          default:
            state_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule // mgmt_serial_slave

// ### rtl/phy_basic_mode_control.v
// Basic mode control register of a 10/100 transceiver, with its
// serial management slave and the MAC-side effects of each control bit.
// Assumes MAC-side and negotiation signals are on ref_clk_i; pins are not.
//
// Function
// - Reset bit resets standard registers, self-clears
// - Vendor-specific registers survive the software reset
// - Reset bit reads 1 while reset runs
// - Loopback routes MAC transmit to MAC receive
// - Forced speed from bit 13 when negotiation off
// - Negotiation on ignores speed and duplex bits
// - Power-down stops MAC and line datapath and clock output, not register access
// - Power-down bit ORed with, set by pin
// - Isolate drops MAC interface and reference clock
// - Restart ignored while negotiation disabled
// - Restart reads 1 until negotiation starts
// - Clearing restart does not stop negotiation
// - Forced duplex from bit 8 when negotiation off
// - Collision test: COL follows TX_EN
// - Frames after gap and one idle high bit
`timescale 1ns/10ps
`include "phy_basic_mode_control_defs.vh"

module phy_basic_mode_control (
  input wire ref_clk_i, // 10 MHz reference clock
  input wire rst_i, // synchronous reset, active high
  input wire mdc_i, // management clock pin
  input wire mdio_i, // management data pin level
  output wire mdio_o, // management data out
  output wire mdio_oe_o, // management data drive enable
  input wire irq_powerdown_pin_n_i, // power-down pin, active low
  input wire negotiation_off_strap_i, // strap, high disables negotiation
  input wire master_mode_i, // reference clock master mode
  input wire neg_speed_100_i, // negotiated speed
  input wire neg_full_duplex_i, // negotiated duplex
  input wire neg_started_i, // pulse: negotiation restarted
  input wire mac_tx_en_i, // MAC transmit enable
  input wire [1:0] mac_txd_i, // MAC transmit data
  input wire line_rx_dv_i, // receive valid from line side
  input wire [1:0] line_rxd_i, // receive data from line side
  output reg mac_rx_dv_o, // MAC receive valid
  output reg [1:0] mac_rxd_o, // MAC receive data
  output reg mac_col_o, // collision to MAC
  output reg line_tx_en_o, // transmit enable to line side
  output reg [1:0] line_txd_o, // transmit data to line side
  output reg ref_clk_out_en_o, // enable of 50 MHz reference output
  output reg speed_100_o, // active speed, high for 100 Mbps
  output reg full_duplex_o, // active duplex, high for full
  output reg neg_enable_o, // negotiation enabled
  output reg neg_restart_o, // pulse: restart negotiation
  output reg power_down_o, // power-down in effect
  output reg isolate_o, // isolation in effect
  output reg std_reset_o // standard registers held in reset
);

  reg pin_s1_q, pin_s2_q, strap_s1_q, strap_s2_q;
  reg [1:0] strap_cnt_q;
  reg strap_q;
  reg srst_q;
  reg [4:0] srst_cnt_q;
  reg loop_q, speed_q, anen_q, pwdn_q, iso_q, restart_q, duplex_q, coltest_q;
  reg [15:0] rd_data;
  wire pin_low;
  wire pd_eff;
  wire [4:0] reg_addr;
  wire [15:0] wr_data;
  wire wr_stb;
  wire ctrl_wr;
  // Bit-selectable copy of the reset word
  localparam [15:0] RST_VAL = `CTRL_RESET;

  assign pin_low = ~pin_s2_q;
  assign pd_eff = pwdn_q | pin_low;
  assign ctrl_wr = wr_stb & (reg_addr == `CTRL_ADDR);

  // ----------------------------------------------------------------------
  // Management port
  // ----------------------------------------------------------------------
  // register access stays alive in power-down
  mgmt_serial_slave u_mgmt (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .rd_data_i(rd_data),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .reg_addr_o(reg_addr),
    .wr_data_o(wr_data),
    .wr_stb_o(wr_stb)
  );

  // Unmapped addresses read zero
  always @*
  begin
    rd_data = 16'h0000;
    if (reg_addr == `CTRL_ADDR)
      rd_data = {srst_q, loop_q, speed_q, anen_q, pd_eff, iso_q, restart_q, duplex_q, coltest_q,
                 {`CTRL_RSVD_W{1'b0}}};
  end

  // ----------------------------------------------------------------------
  // Pin and strap capture
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    pin_s1_q <= irq_powerdown_pin_n_i;
    pin_s2_q <= pin_s1_q;
    strap_s1_q <= negotiation_off_strap_i;
    strap_s2_q <= strap_s1_q;
  end

  // Strap taken once the synchroniser has filled after release
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      strap_cnt_q <= 2'h0;
      strap_q <= 1'b0;
    end
    else if (strap_cnt_q != 2'h3)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2)
        strap_q <= strap_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      srst_q <= 1'b0;
      srst_cnt_q <= 5'h00;
      loop_q <= RST_VAL[`CTRL_LOOP_BIT];
      speed_q <= RST_VAL[`CTRL_SPEED_BIT];
      anen_q <= RST_VAL[`CTRL_ANEN_BIT];
      pwdn_q <= RST_VAL[`CTRL_PWDN_BIT];
      iso_q <= RST_VAL[`CTRL_ISO_BIT];
      restart_q <= RST_VAL[`CTRL_RESTART_BIT];
      duplex_q <= RST_VAL[`CTRL_DUPLEX_BIT];
      coltest_q <= RST_VAL[`CTRL_COLTEST_BIT];
      neg_restart_o <= 1'b0;
    end
    else
    begin
      neg_restart_o <= 1'b0;
      if (strap_cnt_q == 2'h2)
        anen_q <= ~strap_s2_q;
      if (srst_q)
      begin
        srst_cnt_q <= srst_cnt_q - 5'h01;
        if (srst_cnt_q == 5'h01)
        begin
          srst_q <= 1'b0;
          loop_q <= RST_VAL[`CTRL_LOOP_BIT];
          speed_q <= RST_VAL[`CTRL_SPEED_BIT];
          anen_q <= ~strap_q;
          pwdn_q <= RST_VAL[`CTRL_PWDN_BIT];
          iso_q <= RST_VAL[`CTRL_ISO_BIT];
          restart_q <= RST_VAL[`CTRL_RESTART_BIT];
          duplex_q <= RST_VAL[`CTRL_DUPLEX_BIT];
          coltest_q <= RST_VAL[`CTRL_COLTEST_BIT];
        end
      end
      else if (ctrl_wr && wr_data[`CTRL_SRST_BIT])
      begin
        srst_q <= 1'b1;
        srst_cnt_q <= `SRST_CYCLES;
      end
      else
      begin
        if (neg_started_i)
          restart_q <= 1'b0;
        if (ctrl_wr)
        begin
          loop_q <= wr_data[`CTRL_LOOP_BIT];
          speed_q <= wr_data[`CTRL_SPEED_BIT];
          anen_q <= wr_data[`CTRL_ANEN_BIT];
          pwdn_q <= wr_data[`CTRL_PWDN_BIT];
          iso_q <= wr_data[`CTRL_ISO_BIT];
          duplex_q <= wr_data[`CTRL_DUPLEX_BIT];
          coltest_q <= wr_data[`CTRL_COLTEST_BIT];
          if (wr_data[`CTRL_RESTART_BIT] && wr_data[`CTRL_ANEN_BIT])
          begin
            // set wins over start, clears on start
            restart_q <= 1'b1;
            neg_restart_o <= 1'b1;
          end
          // write of 0 only clears the readback
          else if (!wr_data[`CTRL_RESTART_BIT])
            restart_q <= 1'b0;
        end
      end
      // pin low sets the bit, over any write
      if (pin_low)
        pwdn_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Effects on the datapath
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mac_rx_dv_o <= 1'b0;
      mac_rxd_o <= 2'h0;
      mac_col_o <= 1'b0;
      line_tx_en_o <= 1'b0;
      line_txd_o <= 2'h0;
      ref_clk_out_en_o <= 1'b0;
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
      neg_enable_o <= 1'b0;
      power_down_o <= 1'b0;
      isolate_o <= 1'b0;
      std_reset_o <= 1'b0;
    end
    else
    begin
      // only standard registers see this reset
      std_reset_o <= srst_q;
      power_down_o <= pd_eff;
      isolate_o <= iso_q;
      neg_enable_o <= anen_q;
      speed_100_o <= anen_q ? neg_speed_100_i : speed_q;
      full_duplex_o <= anen_q ? neg_full_duplex_i : duplex_q;
      ref_clk_out_en_o <= master_mode_i & ~iso_q & ~pd_eff;
      // Isolated or powered down: MAC side held quiet
      if (iso_q || pd_eff)
      begin
        mac_rx_dv_o <= 1'b0;
        mac_rxd_o <= 2'h0;
        mac_col_o <= 1'b0;
        line_tx_en_o <= 1'b0;
        line_txd_o <= 2'h0;
      end
      else
      begin
        mac_rx_dv_o <= loop_q ? mac_tx_en_i : line_rx_dv_i;
        mac_rxd_o <= loop_q ? mac_txd_i : line_rxd_i;
        line_tx_en_o <= loop_q ? 1'b0 : mac_tx_en_i;
        line_txd_o <= loop_q ? 2'h0 : mac_txd_i;
        // one cycle after TX_EN, well inside limits
        mac_col_o <= coltest_q & mac_tx_en_i;
      end
    end
  end

endmodule // phy_basic_mode_control

// ### rtl/phy_basic_mode_control_defs.vh
// Constants for the basic mode control register and its management port.
// Assumes a single 10 MHz reference clock.
`ifndef PHY_CTRL_DEFS_VH
`define PHY_CTRL_DEFS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CTRL_ADDR 5'h00
`define CTRL_RESET 16'h3100
`define CTRL_SRST_BIT 15
`define CTRL_LOOP_BIT 14
`define CTRL_SPEED_BIT 13
`define CTRL_ANEN_BIT 12
`define CTRL_PWDN_BIT 11
`define CTRL_ISO_BIT 10
`define CTRL_RESTART_BIT 9
`define CTRL_DUPLEX_BIT 8
`define CTRL_COLTEST_BIT 7
`define CTRL_RSVD_W 7

// ----------------------------------------------------------------------
// Management frame
// ----------------------------------------------------------------------
`define MGMT_PHY_ADDR 5'h01
`define MGMT_OP_WRITE 2'h1
`define MGMT_OP_READ 2'h2
`define MGMT_PREAMBLE_BITS 6'h20

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define REF_CLK_PERIOD_NS 100
`define MGMT_GAP_NS 500
`define MGMT_GAP_CYCLES ((`MGMT_GAP_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define SRST_CYCLES 5'h10

`endif

// ### verification/basic_mode_control_properties.sv
// Port checker for the basic mode control block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "phy_basic_mode_control_defs.vh"

module ctrl_properties (
  input wire ref_clk_i, // clock
  input wire rst_i, // reset
  input wire irq_powerdown_pin_n_i, // pin
  input wire neg_speed_100_i, // speed in
  input wire neg_full_duplex_i, // duplex in
  input wire mac_tx_en_i, // tx enable
  input wire [1:0] mac_txd_i, // tx data
  input wire line_rx_dv_i, // line valid
  input wire mdio_o, // data out
  input wire mdio_oe_o, // data enable
  input wire mac_rx_dv_o, // rx valid
  input wire [1:0] mac_rxd_o, // rx data
  input wire mac_col_o, // collision
  input wire ref_clk_out_en_o, // clock enable
  input wire speed_100_o, // speed
  input wire full_duplex_o, // duplex
  input wire neg_enable_o, // negotiation on
  input wire neg_restart_o, // restart pulse
  input wire power_down_o, // power-down
  input wire isolate_o, // isolate
  input wire std_reset_o // soft reset
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // Soft reset length
  // ----
  reg [4:0] run_q;
  wire [4:0] run_d;
  assign run_d = std_reset_o ? run_q + 5'h01 : 5'h00;
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
      run_q <= 5'h00;
    else
      run_q <= run_d;
  end
  // ----
  // Properties
  // ----
  srst_len_a: assert property ($fell(std_reset_o) |-> run_q == `SRST_CYCLES)
    else $error("soft reset length wrong");
  restart_en_a: assert property (neg_restart_o |=> neg_enable_o)
    else $error("restart without negotiation");
  restart_pulse_a: assert property (neg_restart_o |=> !neg_restart_o)
    else $error("restart pulse too long");
  neg_pass_a: assert property (neg_enable_o && $past(neg_enable_o) |->
    speed_100_o == $past(neg_speed_100_i) && full_duplex_o == $past(neg_full_duplex_i))
    else $error("negotiated mode not passed");
  pin_pd_a: assert property ((!irq_powerdown_pin_n_i && !std_reset_o) [*6] |-> power_down_o)
    else $error("pin did not power down");
  iso_quiet_a: assert property (isolate_o && $past(isolate_o) |->
    !mac_rx_dv_o && !mac_col_o && !ref_clk_out_en_o)
    else $error("isolated port still active");
  pd_quiet_a: assert property (power_down_o && $past(power_down_o) |->
    !mac_rx_dv_o && !mac_col_o && !ref_clk_out_en_o)
    else $error("powered-down port still active");
  col_follow_a: assert property (mac_col_o |-> $past(mac_tx_en_i))
    else $error("collision without transmit");
  loop_path_a: assert property (mac_rx_dv_o && !$past(line_rx_dv_i) |-> mac_rxd_o == $past(mac_txd_i))
    else $error("looped data wrong");
  ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not zero");
  cover property ($fell(std_reset_o));
  cover property (neg_restart_o);
  cover property (mac_col_o);
  cover property (mac_rx_dv_o && !$past(line_rx_dv_i));
endmodule // ctrl_properties

bind phy_basic_mode_control ctrl_properties chk_u (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .irq_powerdown_pin_n_i(irq_powerdown_pin_n_i),
  .neg_speed_100_i(neg_speed_100_i), .neg_full_duplex_i(neg_full_duplex_i), .mac_tx_en_i(mac_tx_en_i),
  .mac_txd_i(mac_txd_i), .line_rx_dv_i(line_rx_dv_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .mac_rx_dv_o(mac_rx_dv_o), .mac_rxd_o(mac_rxd_o), .mac_col_o(mac_col_o), .ref_clk_out_en_o(ref_clk_out_en_o),
  .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o), .neg_enable_o(neg_enable_o),
  .neg_restart_o(neg_restart_o), .power_down_o(power_down_o), .isolate_o(isolate_o), .std_reset_o(std_reset_o)
);

// ### verification/mgmt_master_model.sv
// Behavioural management master: frames on the clock and data pins.
// Assumes a pull-up on the data line, resolved by the bench.
`timescale 1ns/10ps
`include "phy_basic_mode_control_defs.vh"

module mgmt_master_model (
  input wire ref_clk_i, // reference clock
  input wire mdio_i, // resolved data line
  output reg mdc_o, // management clock
  output reg mdio_o, // master data
  output reg mdio_oe_o // master drive enable
);
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // Clock phases of four cycles keep well inside the slave's limit
  task one_bit(input logic b, input logic drv, output logic s);
    begin
      @(posedge ref_clk_i);
      mdc_o <= 1'b0;
      mdio_o <= b;
      mdio_oe_o <= drv;
      repeat (4) @(posedge ref_clk_i);
      s = mdio_i;
      mdc_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
    end
  endtask
  task xfer(input logic rd, input logic pre, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rdat);
    logic [31:0] w;
    logic s;
    integer i;
    begin
      w = {2'h1, (rd ? `MGMT_OP_READ : `MGMT_OP_WRITE), pa, ra, 2'h2, wd};
      rdat = 16'h0000;
      repeat (`MGMT_GAP_CYCLES + 3) @(posedge ref_clk_i);
      repeat (pre ? 32 : 1) one_bit(1'b1, 1'b1, s);
      for (i = 31; i >= 0; i = i - 1)
      begin
        one_bit(w[i], !(rd && i < 18), s);
        if (i < 16)
          rdat[i] = s;
      end
      @(posedge ref_clk_i);
      mdc_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask
endmodule // mgmt_master_model

// ### verification/tb.sv
// Self-checking bench for the basic mode control block.
// Assumes the master model and the bound port checker.
`timescale 1ns/10ps
`include "phy_basic_mode_control_defs.vh"

module tb;
  reg ref_clk_i, rst_i, irq_powerdown_pin_n_i, master_mode_i, neg_speed_100_i, neg_full_duplex_i;
  reg neg_started_i, mac_tx_en_i, line_rx_dv_i, negotiation_off_strap_i;
  reg [1:0] mac_txd_i, line_rxd_i;
  wire mdc, m_mdio, m_oe, d_mdio, d_oe, mac_rx_dv_o, mac_col_o, ref_clk_out_en_o, line_tx_en_o;
  wire speed_100_o, full_duplex_o, neg_enable_o, neg_restart_o, power_down_o, isolate_o, std_reset_o;
  wire [1:0] mac_rxd_o, line_txd_o;
  // Pull-up wins when nobody drives
  wire mdio_w = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);
  integer miscompares, samples_checked, cycles, restarts, it, c0;
  reg [31:0] rng_q;
  reg [15:0] d, x;

  mgmt_master_model mm_u (.ref_clk_i(ref_clk_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_mdio), .mdio_oe_o(m_oe));
  phy_basic_mode_control dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(d_mdio), .mdio_oe_o(d_oe),
    .irq_powerdown_pin_n_i(irq_powerdown_pin_n_i), .negotiation_off_strap_i(negotiation_off_strap_i),
    .master_mode_i(master_mode_i),
    .neg_speed_100_i(neg_speed_100_i), .neg_full_duplex_i(neg_full_duplex_i), .neg_started_i(neg_started_i),
    .mac_tx_en_i(mac_tx_en_i), .mac_txd_i(mac_txd_i), .line_rx_dv_i(line_rx_dv_i), .line_rxd_i(line_rxd_i),
    .mac_rx_dv_o(mac_rx_dv_o), .mac_rxd_o(mac_rxd_o), .mac_col_o(mac_col_o),
    .line_tx_en_o(line_tx_en_o), .line_txd_o(line_txd_o),
    .ref_clk_out_en_o(ref_clk_out_en_o), .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
    .neg_enable_o(neg_enable_o), .neg_restart_o(neg_restart_o), .power_down_o(power_down_o),
    .isolate_o(isolate_o), .std_reset_o(std_reset_o)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cycles = cycles + 1;
    if (neg_restart_o === 1'b1)
      restarts = restarts + 1;
    if (cycles == 30000)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  // ----
  // Helpers
  // ----
  function automatic [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [3:0] rx_exp(input [15:0] r);
    begin
      if (r[11] | r[10])
        rx_exp = 4'h0;
      else if (r[14])
        rx_exp = {mac_tx_en_i, mac_txd_i, r[7] & mac_tx_en_i};
      else
        rx_exp = {line_rx_dv_i, line_rxd_i, r[7] & mac_tx_en_i};
    end
  endfunction
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task c1(input string nm, input logic e, input logic g);
    begin
      chk(nm, {15'h0000, e}, {15'h0000, g});
    end
  endtask
  task wr(input logic [4:0] ra, input logic [15:0] v, input logic pre);
    begin
      mm_u.xfer(1'b0, pre, `MGMT_PHY_ADDR, ra, v, x);
    end
  endtask
  task rd_chk(input string nm, input logic [4:0] ra, input logic [15:0] e, input logic pre);
    begin
      mm_u.xfer(1'b1, pre, `MGMT_PHY_ADDR, ra, 16'h0000, x);
      chk(nm, e, x);
    end
  endtask
  task end_test(input string nm);
    begin
      $display("Test %s done", nm);
    end
  endtask
  task wrap_up;
    begin
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    rst_i = 1'b1;
    irq_powerdown_pin_n_i = 1'b1;
    {master_mode_i, neg_speed_100_i, neg_full_duplex_i, neg_started_i, negotiation_off_strap_i} = 5'h00;
    {mac_tx_en_i, mac_txd_i, line_rx_dv_i, line_rxd_i} = 6'h00;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    restarts = 0;
    rng_q = 32'h3FEF;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rd_chk("ctrl", 5'h00, `CTRL_RESET, 1'b1);
    wr(5'h16, 16'h0004, 1'b0);
    rd_chk("unmapped", 5'h16, 16'h0000, 1'b0);
    end_test("defaults");
    for (it = 0; it < 8; it = it + 1)
    begin
      rng_q = xs(rng_q);
      d = rng_q[15:0] & 16'h7DFF;
      case (it)
        0: d = 16'h4000;
        1: d = 16'h2180;
        2: d = 16'h0400;
        3: d = 16'h0800;
        default: ;
      endcase
      master_mode_i <= rng_q[16];
      neg_speed_100_i <= rng_q[17];
      neg_full_duplex_i <= rng_q[18];
      wr(5'h00, d, rng_q[19]);
      rd_chk("ctrl", 5'h00, d & 16'h7D80, rng_q[20]);
      @(posedge ref_clk_i);
      mac_tx_en_i <= rng_q[21] | (it < 2);
      mac_txd_i <= rng_q[23:22];
      line_rx_dv_i <= rng_q[24] & (it != 0);
      line_rxd_i <= rng_q[26:25];
      repeat (3) @(posedge ref_clk_i);
      chk("rx_col", {12'h000, rx_exp(d)}, {12'h000, mac_rx_dv_o, mac_rxd_o, mac_col_o});
      c1("speed", d[12] ? neg_speed_100_i : d[13], speed_100_o);
      c1("duplex", d[12] ? neg_full_duplex_i : d[8], full_duplex_o);
      c1("neg_en", d[12], neg_enable_o);
      c1("isolate", d[10], isolate_o);
      c1("pdown", d[11], power_down_o);
      c1("refclk", master_mode_i & ~d[10] & ~d[11], ref_clk_out_en_o);
      chk("line_tx", (d & 16'h4C00) ? 16'h0000 : {13'h0000, mac_tx_en_i, mac_txd_i},
          {13'h0000, line_tx_en_o, line_txd_o});
    end
    end_test("fields");
    c0 = restarts;
    wr(5'h00, 16'h1200, 1'b0);
    rd_chk("restart", 5'h00, 16'h1200, 1'b0);
    @(posedge ref_clk_i);
    neg_started_i <= 1'b1;
    @(posedge ref_clk_i);
    neg_started_i <= 1'b0;
    rd_chk("restart", 5'h00, 16'h1000, 1'b0);
    wr(5'h00, 16'h1200, 1'b0);
    wr(5'h00, 16'h1000, 1'b0);
    c1("neg_keep", 1'b1, neg_enable_o);
    wr(5'h00, 16'h0200, 1'b0);
    rd_chk("restart", 5'h00, 16'h0000, 1'b0);
    c1("restarts", 1'b1, restarts == c0 + 2);
    end_test("restart");
    @(posedge ref_clk_i);
    irq_powerdown_pin_n_i <= 1'b0;
    wr(5'h00, 16'h0000, 1'b0);
    rd_chk("pin", 5'h00, 16'h0800, 1'b0);
    c1("pdown", 1'b1, power_down_o);
    irq_powerdown_pin_n_i <= 1'b1;
    rd_chk("pin", 5'h00, 16'h0800, 1'b0);
    end_test("pin");
    wr(5'h00, 16'h0480, 1'b0);
    wr(5'h00, 16'h8000, 1'b0);
    c1("srst", 1'b1, std_reset_o);
    repeat (20) @(posedge ref_clk_i);
    c1("srst", 1'b0, std_reset_o);
    rd_chk("srst", 5'h00, `CTRL_RESET, 1'b0);
    end_test("soft_reset");
    mm_u.xfer(1'b0, 1'b0, 5'h02, 5'h00, 16'h0400, x);
    mm_u.xfer(1'b1, 1'b0, 5'h02, 5'h00, 16'h0000, x);
    chk("foreign", 16'hFFFF, x);
    rd_chk("foreign", 5'h00, `CTRL_RESET, 1'b0);
    end_test("address");
    // Strap high across a second reset: negotiation starts disabled
    negotiation_off_strap_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rd_chk("strap", 5'h00, `CTRL_RESET & 16'hEFFF, 1'b1);
    c1("neg_en", 1'b0, neg_enable_o);
    end_test("strap");
    wrap_up;
  end
endmodule // tb
